// ---- verilog/bca_map.svh ----
// Constants of the bridge central arbiter: agent counts and timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef BCA_MAP_SVH
`define BCA_MAP_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define BCA_NUM_AGENTS      4
`define BCA_MAX_AGENTS      8

// ----------------------------------------------------------------------
// Timing counts, in clock cycles
// ----------------------------------------------------------------------
// Grant without FRAME is withdrawn after this many cycles
`define BCA_GNT_IDLE_CYCLES 16

`endif

// ---- verilog/bca_pkg.sv ----
// Types shared by the bridge central arbiter modules.
// Assumes bca_map.svh is on the include path.
`include "bca_map.svh"

package bca_pkg;

	// ------------------------------------------------------------------
	// Ownership state machine, one-hot
	// ------------------------------------------------------------------
	typedef enum logic [5:0] {
		ST_HOST      = 6'h01,
		ST_PCI_HOLD  = 6'h02,
		ST_PCI_OWN   = 6'h04,
		ST_PCI_STOP  = 6'h08,
		ST_CORE_WAIT = 6'h10,
		ST_CORE_OWN  = 6'h20
	} bca_state_e;

	typedef logic [2:0] bca_rank_t;

endpackage

// ---- verilog/bca_age_tracker.sv ----
// Priority ranks of the PCI agents for the rotating scheme.
// Assumes a one-hot take vector pulsed for one cycle per grant.
`timescale 1ns/1ns
`default_nettype none
`include "bca_map.svh"

module bca_age_tracker #(
	parameter int N_AGENTS = `BCA_NUM_AGENTS
) (
	input  wire logic                  i_clk,
	input  wire logic                  i_reset,
	input  wire logic                  i_take,
	input  wire logic [N_AGENTS-1:0]   i_take_onehot,
	output logic      [N_AGENTS*3-1:0] o_rank
);

	if (N_AGENTS < 2 || N_AGENTS > `BCA_MAX_AGENTS) begin : g_bad_agents
		$error("N_AGENTS must lie between 2 and 8");
	end

	// ------------------------------------------------------------------
	// Ranks: highest rank waited longest; agent 0 starts highest
	// ------------------------------------------------------------------
	bca_pkg::bca_rank_t rank_q [N_AGENTS];
	bca_pkg::bca_rank_t rank_d [N_AGENTS];
	bca_pkg::bca_rank_t taken;

	always_comb begin
		taken = '0;
		for (int i = 0; i < N_AGENTS; i++) begin
			rank_d[i] = rank_q[i];
			if (i_take_onehot[i]) begin
				taken = rank_q[i];
			end
		end
		if (i_take) begin
			for (int i = 0; i < N_AGENTS; i++) begin
				if (i_take_onehot[i]) begin
					rank_d[i] = '0;
				end else if (rank_q[i] < taken) begin
					rank_d[i] = rank_q[i] + 3'h1;
				end
			end
		end
	end

	always_ff @(posedge i_clk) begin
		for (int i = 0; i < N_AGENTS; i++) begin
			if (i_reset) begin
				rank_q[i] <= 3'(N_AGENTS - 1 - i);
			end else begin
				rank_q[i] <= rank_d[i];
			end
		end
	end

	always_comb begin
		for (int i = 0; i < N_AGENTS; i++) begin
			o_rank[i*3 +: 3] = rank_q[i];
		end
	end

endmodule

`default_nettype wire

// ---- verilog/bca_prio_pick.sv ----
// Picks one PCI requester by fixed or rotating priority.
// Assumes requests active high and ranks forming a permutation.
`timescale 1ns/1ns
`default_nettype none
`include "bca_map.svh"

module bca_prio_pick #(
	parameter int N_AGENTS = `BCA_NUM_AGENTS
) (
	input  wire logic [N_AGENTS-1:0]   i_req,
	input  wire logic [N_AGENTS*3-1:0] i_rank,
	input  wire logic                  i_rotate,
	output logic      [N_AGENTS-1:0]   o_win
);

	if (N_AGENTS < 2 || N_AGENTS > `BCA_MAX_AGENTS) begin : g_bad_agents
		$error("N_AGENTS must lie between 2 and 8");
	end

	// ------------------------------------------------------------------
	// Highest ranked requester wins; fixed rank favours the low index
	// ------------------------------------------------------------------
	bca_pkg::bca_rank_t best;
	bca_pkg::bca_rank_t cur;

	always_comb begin
		o_win = '0;
		best  = '0;
		cur   = '0;
		for (int i = 0; i < N_AGENTS; i++) begin
			cur = i_rotate ? i_rank[i*3 +: 3]
				: 3'(N_AGENTS - 1 - i);
			if (i_req[i] && (o_win == '0 || cur > best)) begin
				o_win = '0;
				o_win[i] = 1'b1;
				best = cur;
			end
		end
	end

endmodule

`default_nettype wire

// ---- verilog/bca_central_arbiter.sv ----
// Central arbiter of the processor-bus to PCI bridge.
// Assumes all inputs synchronous to I_SYS_CLK and decoding done elsewhere.
`timescale 1ns/1ns
`default_nettype none
`include "bca_map.svh"

module bca_central_arbiter #(
	parameter int N_AGENTS   = `BCA_NUM_AGENTS,
	parameter int IDLE_LIMIT = `BCA_GNT_IDLE_CYCLES
) (
	input  wire logic                I_SYS_CLK,
	input  wire logic                I_RESET,
	input  wire logic [N_AGENTS-1:0] I_PCI_REQ_N,
	input  wire logic                I_PCI_FRAME_N,
	input  wire logic                I_PCI_IRDY_N,
	input  wire logic                I_CORE_LOGIC_HOLD_REQUEST,
	input  wire logic                I_PROCESSOR_HOLD_ACK,
	input  wire logic                I_ROTATE_PRIORITY,
	input  wire logic                I_PROCESSOR_CYCLE,
	input  wire logic                I_BRIDGE_MASTER_BUSY,
	input  wire logic                I_HOST_SIDE_TARGET,
	input  wire logic                I_DOWNSTREAM_FIFO_CMD,
	output logic      [N_AGENTS-1:0] O_PCI_GNT_N,
	output logic                     O_CORE_LOGIC_HOLD_ACK,
	output logic                     O_PROCESSOR_HOLD_REQUEST,
	output logic                     O_HOST_BUS_OWNER,
	output logic                     O_DOWNSTREAM_OWNER,
	output logic                     O_DOWNSTREAM_CLAIM,
	output logic                     O_UPSTREAM_RUN,
	output logic                     O_BRIDGE_DRAIN_EN,
	output logic                     O_PCI_PREEMPT
);

	// ------------------------------------------------------------------
	// Parameter checks
	// ------------------------------------------------------------------
	// Idle counter wide enough to hold the limit itself
	localparam int IW = $clog2(IDLE_LIMIT + 1);

	if (N_AGENTS < 2 || N_AGENTS > `BCA_MAX_AGENTS) begin : g_bad_agents
		$error("N_AGENTS must lie between 2 and 8");
	end
	// Idle counter needs at least one cycle to count
	if (IDLE_LIMIT < 1) begin : g_bad_idle
		$error("IDLE_LIMIT must be at least 1");
	end

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	bca_pkg::bca_state_e   state_q;
	bca_pkg::bca_state_e   state_d;
	logic [N_AGENTS-1:0]   gnt_q;
	logic [N_AGENTS-1:0]   gnt_d;
	logic                  phold_q;
	logic                  phold_d;
	logic                  cack_q;
	logic                  cack_d;
	logic                  preempt_q;
	logic                  preempt_d;
	logic                  started_q;
	logic                  started_d;
	logic [IW-1:0]         idle_q;
	logic [IW-1:0]         idle_d;
	logic                  down_q;
	logic                  down_d;
	logic                  claim_q;
	logic                  claim_d;
	logic                  run_q;
	logic                  run_d;
	logic                  drain_q;
	logic                  drain_d;
	logic [N_AGENTS-1:0]   gnt_n_q;
	logic [N_AGENTS-1:0]   gnt_n_d;
	logic                  host_q;
	logic                  host_d;
	logic                  take;
	logic [N_AGENTS-1:0]   req;
	logic [N_AGENTS-1:0]   win;
	logic [N_AGENTS*3-1:0] rank;
	logic                  any_req;
	logic                  core_req;
	logic                  bus_idle;
	logic                  pci_blocked;

	// ------------------------------------------------------------------
	// Input decoding
	// ------------------------------------------------------------------
	// One request line per agent, never shared
	assign req         = ~I_PCI_REQ_N;
	assign any_req     = |req;
	assign core_req    = I_CORE_LOGIC_HOLD_REQUEST;
	// Bus idle needs FRAME and IRDY both high
	assign bus_idle    = I_PCI_FRAME_N && I_PCI_IRDY_N;
	assign pci_blocked = I_PROCESSOR_CYCLE || I_BRIDGE_MASTER_BUSY;

	// ------------------------------------------------------------------
	// Priority selection
	// ------------------------------------------------------------------
	bca_prio_pick #(
		.N_AGENTS (N_AGENTS)
	) u_pick (
		.i_req    (req),
		.i_rank   (rank),
		.i_rotate (I_ROTATE_PRIORITY),
		.o_win    (win)
	);

	// Rank update uses the grant vector itself as the one-hot
	bca_age_tracker #(
		.N_AGENTS      (N_AGENTS)
	) u_age (
		.i_clk         (I_SYS_CLK),
		.i_reset       (I_RESET),
		.i_take        (take),
		.i_take_onehot (gnt_d),
		.o_rank        (rank)
	);

	// ------------------------------------------------------------------
	// Ownership state machine
	// ------------------------------------------------------------------
	always_comb begin
		state_d   = state_q;
		gnt_d     = gnt_q;
		phold_d   = phold_q;
		cack_d    = cack_q;
		preempt_d = 1'b0;
		started_d = started_q;
		idle_d    = idle_q;
		take      = 1'b0;
		unique case (state_q)
			bca_pkg::ST_HOST: begin
				gnt_d   = '0;
				cack_d  = 1'b0;
				phold_d = 1'b0;
				// Core logic wins over PCI requesters
				if (core_req) begin
					phold_d = 1'b1;
					state_d = bca_pkg::ST_CORE_WAIT;
				end else if (any_req && !pci_blocked) begin
					phold_d = 1'b1;
					state_d = bca_pkg::ST_PCI_HOLD;
				end
			end
			bca_pkg::ST_PCI_HOLD: begin
				if (core_req) begin
					state_d = bca_pkg::ST_CORE_WAIT;
				end else if (!any_req) begin
					phold_d = 1'b0;
					state_d = bca_pkg::ST_HOST;
				// Hold kept between grants: no new handshake
				end else if (I_PROCESSOR_HOLD_ACK && !pci_blocked) begin
					gnt_d     = win;
					take      = 1'b1;
					started_d = 1'b0;
					idle_d    = '0;
					state_d   = bca_pkg::ST_PCI_OWN;
				end
			end
			bca_pkg::ST_PCI_OWN: begin
				if (core_req) begin
					gnt_d = '0;
					if (started_q && !bus_idle) begin
						preempt_d = 1'b1;
						state_d   = bca_pkg::ST_PCI_STOP;
					end else begin
						state_d = bca_pkg::ST_CORE_WAIT;
					end
				end else if (!started_q) begin
					// Unused grant is withdrawn so others are not starved
					if (!I_PCI_FRAME_N) begin
						started_d = 1'b1;
					end else if (idle_q == IW'(IDLE_LIMIT - 1)) begin
						gnt_d   = '0;
						state_d = bca_pkg::ST_PCI_HOLD;
					end else begin
						idle_d = idle_q + IW'(1);
					end
				end else if (bus_idle) begin
					gnt_d   = '0;
					state_d = bca_pkg::ST_PCI_HOLD;
				end
			end
			bca_pkg::ST_PCI_STOP: begin
				// Agent told to stop; wait until the bus is idle
				if (bus_idle) begin
					state_d = bca_pkg::ST_CORE_WAIT;
				end else begin
					preempt_d = 1'b1;
				end
			end
			bca_pkg::ST_CORE_WAIT: begin
				phold_d = 1'b1;
				// Core logic may give up before the processor lets go
				if (!core_req) begin
					state_d = bca_pkg::ST_HOST;
				end else if (I_PROCESSOR_HOLD_ACK) begin
					cack_d  = 1'b1;
					state_d = bca_pkg::ST_CORE_OWN;
				end
			end
			bca_pkg::ST_CORE_OWN: begin
				if (!core_req) begin
					cack_d  = 1'b0;
					phold_d = 1'b0;
					state_d = bca_pkg::ST_HOST;
				end
			end
		endcase
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			state_q   <= bca_pkg::ST_HOST;
			gnt_q     <= '0;
			phold_q   <= 1'b0;
			cack_q    <= 1'b0;
			preempt_q <= 1'b0;
			started_q <= 1'b0;
			idle_q    <= '0;
		end else begin
			state_q   <= state_d;
			gnt_q     <= gnt_d;
			phold_q   <= phold_d;
			cack_q    <= cack_d;
			preempt_q <= preempt_d;
			started_q <= started_d;
			idle_q    <= idle_d;
		end
	end

	// ------------------------------------------------------------------
	// Sequencer ownership and control
	// ------------------------------------------------------------------
	always_comb begin
		down_d = (state_d == bca_pkg::ST_PCI_OWN)
			|| (state_d == bca_pkg::ST_PCI_STOP);
		claim_d = (state_q == bca_pkg::ST_PCI_OWN)
			&& !I_PCI_FRAME_N && I_HOST_SIDE_TARGET;
		run_d = down_q && I_DOWNSTREAM_FIFO_CMD;
		drain_d = !down_d;
		// Grant and owner pins are registered copies of the next state
		gnt_n_d = ~gnt_d;
		host_d = !down_d;
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			down_q  <= 1'b0;
			claim_q <= 1'b0;
			run_q   <= 1'b0;
			drain_q <= 1'b1;
			gnt_n_q <= '1;
			host_q  <= 1'b1;
		end else begin
			down_q  <= down_d;
			claim_q <= claim_d;
			run_q   <= run_d;
			drain_q <= drain_d;
			gnt_n_q <= gnt_n_d;
			host_q  <= host_d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs, all from flip-flops
	// ------------------------------------------------------------------
	assign O_PCI_GNT_N              = gnt_n_q;
	assign O_PROCESSOR_HOLD_REQUEST = phold_q;
	assign O_CORE_LOGIC_HOLD_ACK    = cack_q;
	assign O_PCI_PREEMPT            = preempt_q;
	assign O_DOWNSTREAM_OWNER       = down_q;
	assign O_HOST_BUS_OWNER         = host_q;
	assign O_DOWNSTREAM_CLAIM       = claim_q;
	assign O_UPSTREAM_RUN           = run_q;
	assign O_BRIDGE_DRAIN_EN        = drain_q;

endmodule

`default_nettype wire

// ---- sim/bca_cpu_model.sv ----
// Processor model: acknowledges hold once its own cycle is over.
// Assumes a level hold request, synchronous to the bench clock.
`timescale 1ns/1ns
`default_nettype none
module bca_cpu_model (
	input  wire logic       i_clk,
	input  wire logic       i_reset,
	input  wire logic       i_hold_req,
	input  wire logic       i_busy,
	input  wire logic [3:0] i_lat,
	output logic            o_hold_ack
);
	logic [3:0] cnt_q;
	always_ff @(posedge i_clk) begin
		if (i_reset || !i_hold_req) begin
			cnt_q <= 4'h0;
			o_hold_ack <= 1'b0;
		end else if (!i_busy) begin
			if (cnt_q != i_lat)
				cnt_q <= cnt_q + 4'h1;
			o_hold_ack <= (cnt_q == i_lat);
		end
	end
endmodule
`default_nettype wire

// ---- sim/bca_central_arbiter_assertions.sv ----
// Port checker of the bridge central arbiter.
// Assumes a bind to bca_central_arbiter; one clock, sync reset.
`timescale 1ns/1ns
`default_nettype none
module bca_central_arbiter_assertions #(
	parameter int N_AGENTS = 4
) (
	input wire logic                I_SYS_CLK,
	input wire logic                I_RESET,
	input wire logic                I_PCI_FRAME_N,
	input wire logic                I_CORE_LOGIC_HOLD_REQUEST,
	input wire logic                I_PROCESSOR_HOLD_ACK,
	input wire logic                I_PROCESSOR_CYCLE,
	input wire logic                I_BRIDGE_MASTER_BUSY,
	input wire logic                I_DOWNSTREAM_FIFO_CMD,
	input wire logic [N_AGENTS-1:0] O_PCI_GNT_N,
	input wire logic                O_CORE_LOGIC_HOLD_ACK,
	input wire logic                O_PROCESSOR_HOLD_REQUEST,
	input wire logic                O_HOST_BUS_OWNER,
	input wire logic                O_DOWNSTREAM_OWNER,
	input wire logic                O_UPSTREAM_RUN
);
	wire gnt_any = ~&O_PCI_GNT_N;
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (I_RESET);
	property p_one_gnt;
		$onehot0(~O_PCI_GNT_N);
	endproperty
	a_one_gnt: assert property (p_one_gnt)
		else $error("two grants low");
	property p_owner;
		O_HOST_BUS_OWNER != O_DOWNSTREAM_OWNER;
	endproperty
	a_owner: assert property (p_owner)
		else $error("owner not exclusive");
	property p_hold_first;
		$fell(&O_PCI_GNT_N) |->
			$past(I_PROCESSOR_HOLD_ACK) && O_PROCESSOR_HOLD_REQUEST;
	endproperty
	a_hold_first: assert property (p_hold_first)
		else $error("grant without hold");
	property p_no_block;
		$fell(&O_PCI_GNT_N) |-> !$past(I_PROCESSOR_CYCLE) &&
			!$past(I_BRIDGE_MASTER_BUSY) && !$past(I_CORE_LOGIC_HOLD_REQUEST);
	endproperty
	a_no_block: assert property (p_no_block)
		else $error("grant while blocked");
	property p_fwd;
		I_CORE_LOGIC_HOLD_REQUEST |=> O_PROCESSOR_HOLD_REQUEST;
	endproperty
	a_fwd: assert property (p_fwd)
		else $error("hold not forwarded");
	property p_core_ack;
		$rose(O_CORE_LOGIC_HOLD_ACK) |->
			$past(I_PROCESSOR_HOLD_ACK) && $past(I_CORE_LOGIC_HOLD_REQUEST);
	endproperty
	a_core_ack: assert property (p_core_ack)
		else $error("core ack without cause");
	property p_preempt;
		I_CORE_LOGIC_HOLD_REQUEST && gnt_any |=> &O_PCI_GNT_N;
	endproperty
	a_preempt: assert property (p_preempt)
		else $error("grant not cut");
	property p_keep;
		gnt_any && !I_PCI_FRAME_N && !I_CORE_LOGIC_HOLD_REQUEST
			|=> $stable(O_PCI_GNT_N);
	endproperty
	a_keep: assert property (p_keep)
		else $error("grant lost mid transfer");
	property p_upstream;
		O_UPSTREAM_RUN |->
			$past(O_DOWNSTREAM_OWNER) && $past(I_DOWNSTREAM_FIFO_CMD);
	endproperty
	a_upstream: assert property (p_upstream)
		else $error("upstream ran undirected");
endmodule
`default_nettype wire

// ---- sim/tb_bca_central_arbiter.sv ----
// Self-checking bench of the bridge central arbiter.
// Assumes the design, checker and processor model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_bca_central_arbiter;
	logic       clk, rst, frame_n, irdy_n, core_req, rot, pcyc, busy;
	logic       host_tgt, fifo_cmd, cpu_ack, core_ack, hold_req;
	logic       host_own, down_own, claim, up_run, drain, preempt;
	logic [3:0] req_n, gnt_n, lat;
	int         n_mismatch, checks_done;
	bca_central_arbiter #(.N_AGENTS(4), .IDLE_LIMIT(4)) bca_central_arbiter_i (
		.I_SYS_CLK(clk), .I_RESET(rst), .I_PCI_REQ_N(req_n),
		.I_PCI_FRAME_N(frame_n), .I_PCI_IRDY_N(irdy_n),
		.I_CORE_LOGIC_HOLD_REQUEST(core_req), .I_PROCESSOR_HOLD_ACK(cpu_ack),
		.I_ROTATE_PRIORITY(rot), .I_PROCESSOR_CYCLE(pcyc),
		.I_BRIDGE_MASTER_BUSY(busy), .I_HOST_SIDE_TARGET(host_tgt),
		.I_DOWNSTREAM_FIFO_CMD(fifo_cmd), .O_PCI_GNT_N(gnt_n),
		.O_CORE_LOGIC_HOLD_ACK(core_ack), .O_PROCESSOR_HOLD_REQUEST(hold_req),
		.O_HOST_BUS_OWNER(host_own), .O_DOWNSTREAM_OWNER(down_own),
		.O_DOWNSTREAM_CLAIM(claim), .O_UPSTREAM_RUN(up_run),
		.O_BRIDGE_DRAIN_EN(drain), .O_PCI_PREEMPT(preempt));
	bca_cpu_model bca_cpu_model_i (.i_clk(clk), .i_reset(rst),
		.i_hold_req(hold_req), .i_busy(pcyc), .i_lat(lat),
		.o_hold_ack(cpu_ack));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wait_gnt();
		for (int i = 0; i < 30 && gnt_n === 4'hF; i++)
			cyc(1);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic do_reset();
		@(posedge clk) rst <= 1'b1;
		cyc(8);
		chk("rgnt", 8'h0F, gnt_n);
		chk("rhost", 1, host_own);
		chk("rdown", 0, down_own);
		chk("rdrain", 1, drain);
		chk("rhold", 0, hold_req);
		chk("rcack", 0, core_ack);
		@(posedge clk) rst <= 1'b0;
		cyc(1);
	endtask
	// One granted PCI transfer, requests withdrawn once FRAME is low
	task automatic xfer(logic [3:0] r, logic [3:0] e);
		@(posedge clk) req_n <= r;
		cyc(1);
		wait_gnt();
		chk("gnt", e, gnt_n);
		chk("down", 1, down_own);
		chk("drain", 0, drain);
		@(posedge clk) frame_n <= 1'b0;
		irdy_n <= 1'b0;
		req_n <= 4'hF;
		cyc(3);
		chk("keep", e, gnt_n);
		@(posedge clk) frame_n <= 1'b1;
		cyc(2);
		chk("last", e, gnt_n);
		@(posedge clk) irdy_n <= 1'b1;
		cyc(3);
		chk("rel", 8'h0F, gnt_n);
		chk("home", 1, host_own);
	endtask
	task automatic t_fixed();
		@(posedge clk) rot <= 1'b0;
		xfer(4'h0, 4'hE);
		xfer(4'h9, 4'hD);
		xfer(4'h7, 4'h7);
		$display("fixed priority done");
	endtask
	task automatic t_rotate();
		do_reset();
		@(posedge clk) rot <= 1'b1;
		for (int i = 0; i < 5; i++)
			xfer(4'h0, ~(4'h1 << (i % 4)));
		xfer(4'h6, 4'h7);
		$display("rotating priority done");
	endtask
	task automatic t_block();
		for (int k = 0; k < 2; k++) begin
			@(posedge clk) pcyc <= (k == 0);
			busy <= (k == 1);
			req_n <= 4'hB;
			cyc(8);
			chk("blk", 8'h0F, gnt_n);
			chk("bhold", 0, hold_req);
			@(posedge clk) pcyc <= 1'b0;
			busy <= 1'b0;
			cyc(1);
			wait_gnt();
			chk("unblk", 4'hB, gnt_n);
			@(posedge clk) req_n <= 4'hF;
			cyc(10);
			chk("idle", 8'h0F, gnt_n);
		end
		$display("blocking done");
	endtask
	task automatic t_core();
		@(posedge clk) lat <= 4'h3;
		req_n <= 4'hD;
		cyc(1);
		wait_gnt();
		@(posedge clk) frame_n <= 1'b0;
		req_n <= 4'hF;
		@(posedge clk) core_req <= 1'b1;
		cyc(2);
		chk("cut", 8'h0F, gnt_n);
		chk("pre", 1, preempt);
		chk("fwd", 1, hold_req);
		chk("early", 0, core_ack);
		@(posedge clk) frame_n <= 1'b1;
		cyc(12);
		chk("cack", 1, core_ack);
		chk("pre0", 0, preempt);
		@(posedge clk) core_req <= 1'b0;
		cyc(2);
		chk("cack0", 0, core_ack);
		chk("hold0", 0, hold_req);
		@(posedge clk) lat <= 4'h0;
		$display("core hold done");
	endtask
	task automatic t_claim();
		@(posedge clk) host_tgt <= 1'b1;
		fifo_cmd <= 1'b1;
		cyc(3);
		chk("run0", 0, up_run);
		chk("clm0", 0, claim);
		@(posedge clk) req_n <= 4'h7;
		cyc(1);
		wait_gnt();
		@(posedge clk) frame_n <= 1'b0;
		req_n <= 4'hF;
		cyc(3);
		chk("clm", 1, claim);
		chk("run", 1, up_run);
		@(posedge clk) frame_n <= 1'b1;
		host_tgt <= 1'b0;
		fifo_cmd <= 1'b0;
		cyc(6);
		chk("run1", 0, up_run);
		$display("claim done");
	endtask
	initial begin
		{rst, frame_n, irdy_n} = 3'h7;
		{core_req, rot, pcyc, busy, host_tgt, fifo_cmd} = 6'h00;
		req_n = 4'hF;
		lat = 4'h0;
		n_mismatch = 0;
		checks_done = 0;
		do_reset();
		t_fixed();
		t_block();
		t_core();
		t_claim();
		t_rotate();
		wrap_up();
	end
	initial begin
		#100000;
		n_mismatch++;
		wrap_up();
	end
endmodule
bind bca_central_arbiter bca_central_arbiter_assertions #(
	.N_AGENTS(N_AGENTS)) chk_i (.I_SYS_CLK, .I_RESET, .I_PCI_FRAME_N,
	.I_CORE_LOGIC_HOLD_REQUEST, .I_PROCESSOR_HOLD_ACK, .I_PROCESSOR_CYCLE,
	.I_BRIDGE_MASTER_BUSY, .I_DOWNSTREAM_FIFO_CMD, .O_PCI_GNT_N,
	.O_CORE_LOGIC_HOLD_ACK, .O_PROCESSOR_HOLD_REQUEST, .O_HOST_BUS_OWNER,
	.O_DOWNSTREAM_OWNER, .O_UPSTREAM_RUN);
`default_nettype wire
